// ---- rtl/npc_config_regs.sv ----
// Purpose: Protocol configuration bank: three registers and their decoded controls
// Assumes: Strobes, command pulses and frame inputs come from mclk-domain logic
// Notes:   All outputs are registered; decoded controls follow the registers one enabled cycle later, fieldOnN is captured at a field-on start
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module npc_config_regs #(
  parameter int FDT_W = 16,                        // Width of the frame delay count
  parameter logic [15:0] NOMINAL_FDT_FC = 16'h0400 // Nominal frame delay, in 1/fc periods
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [7:0] rdData,
  input wire logic txReqaCmd,
  input wire logic txWupaCmd,
  input wire logic antiCollFrame,
  input wire logic rxFrameDone,
  input wire logic fieldOnCmd,
  input wire logic fieldOnDone,
  output logic [FDT_W-1:0] fdtCount,
  output npc_pkg::npc_target_t target,
  output npc_pkg::npc_stream_t stream,
  output logic rxCrcCheck,
  output logic idValid,
  output logic [2:0] idBytes,
  output logic phaseShift90,
  output logic rxCorrelation,
  output logic rxModeInvalid,
  output logic fieldOnBusy,
  output logic [1:0] fieldOnN
);
  import npc_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] passiveReg; // passive_target_definition
  logic [7:0] streamReg;  // stream_mode_definition
  logic [7:0] auxReg;     // auxiliary_definition
  logic skipCrcResp;      // Waiting for a REQA or WUPA answer
  npc_fon_state_t fonState; // Field-on command tracker
  npc_stream_t next_stream; // Decoded stream settings

  // Reserved bits are masked out at write time
  npc_reg8 #(.WMASK(MASK_PASSIVE), .RESET(RESET_VAL)) uPassive (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wrEn(wrStrobe && (addr == ADDR_PASSIVE)),
    .wrData(wrData),
    .q(passiveReg)
  );

  npc_reg8 #(.WMASK(MASK_STREAM), .RESET(RESET_VAL)) uStream (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wrEn(wrStrobe && (addr == ADDR_STREAM)),
    .wrData(wrData),
    .q(streamReg)
  );

  npc_reg8 #(.WMASK(MASK_AUX), .RESET(RESET_VAL)) uAux (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .wrEn(wrStrobe && (addr == ADDR_AUX)),
    .wrData(wrData),
    .q(auxReg)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData <= READ_IDLE;
    end else if (ce) begin
      if (rdStrobe) begin
        case (addr)
          ADDR_PASSIVE: rdData <= passiveReg;
          ADDR_STREAM: rdData <= streamReg;
          ADDR_AUX: rdData <= auxReg;
          default: rdData <= READ_IDLE; // Unmapped reads as zero
        endcase
      end else begin
        rdData <= READ_IDLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Target-mode controls
  // ----------------------------------------------------------------
  // Frame delay, shortened by the trim in carrier periods; the host
  // normally programs a trim of two
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fdtCount <= NOMINAL_FDT_FC[FDT_W-1:0];
    end else if (ce) begin
      fdtCount <= NOMINAL_FDT_FC[FDT_W-1:0]
                  - FDT_W'(passiveReg[FDEL_LSB +: 4]);
    end
  end

  // Automatic answers, each active while its disable bit is clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      target <= '0;
    end else if (ce) begin
      target.ap2pRecogEn <= ~passiveReg[AP2P_BIT];
      target.autoTypeFEn <= ~passiveReg[TYPEF_BIT];
      target.autoTypeAEn <= ~passiveReg[TYPEA_BIT];
      // With both answers off, framing hands every exchange to the FIFO
      target.fifoOnly <= passiveReg[TYPEF_BIT] & passiveReg[TYPEA_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Stream-mode decode
  // ----------------------------------------------------------------
  // Turn the three stream fields into dividers and valid flags
  always_comb begin
    next_stream = '0;
    // Stream frequency: reserved codes leave both modes off
    case (streamReg[SCF_LSB +: 2])
      SCF_SUB: begin
        next_stream.subMode = 1'b1;
        next_stream.scDiv = DIV_SUB;
      end
      SCF_BPSK: begin
        next_stream.bpskMode = 1'b1;
        next_stream.scDiv = DIV_BPSK;
      end
      default: next_stream.scDiv = 8'h00;
    endcase
    // Pulse count: low codes are reserved
    case (streamReg[SCP_LSB +: 2])
      SCP_FOUR: begin
        next_stream.pulseValid = 1'b1;
        next_stream.pulses = PULSES_FOUR;
      end
      SCP_EIGHT: begin
        next_stream.pulseValid = 1'b1;
        next_stream.pulses = PULSES_EIGHT;
      end
      default: next_stream.pulses = 4'h0;
    endcase
    // Modulator period: each code step halves the divider
    if (!streamReg[STX_LSB + 2]) begin
      next_stream.txValid = 1'b1;
      next_stream.txDiv = DIV_TX_BASE >> streamReg[STX_LSB +: 2];
    end
  end

  // Register the decoded stream settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stream <= '0;
    end else if (ce) begin
      stream <= next_stream;
    end
  end

  // ----------------------------------------------------------------
  // Receive CRC handling
  // ----------------------------------------------------------------
  // Remember that a REQA or WUPA answer is due; a new command wins
  // over the end of the previous frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      skipCrcResp <= 1'b0;
    end else if (ce) begin
      if (txReqaCmd || txWupaCmd) begin
        skipCrcResp <= 1'b1;
      end else if (rxFrameDone) begin
        skipCrcResp <= 1'b0;
      end
    end
  end

  // Check CRC unless disabled, awaiting a REQA/WUPA answer, or in
  // anticollision framing (set by the host only for reader anticollision)
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxCrcCheck <= 1'b0;
    end else if (ce) begin
      rxCrcCheck <= ~auxReg[CRC_BIT]
                    & ~skipCrcResp & ~antiCollFrame;
    end
  end

  // ----------------------------------------------------------------
  // Auxiliary controls
  // ----------------------------------------------------------------
  // Identifier size, phase clock and receiver operation
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      idValid <= 1'b0;
      idBytes <= 3'h0;
      phaseShift90 <= 1'b0;
      rxCorrelation <= 1'b0;
      rxModeInvalid <= 1'b0;
    end else if (ce) begin
      case (auxReg[IDSZ_LSB +: 2])
        IDSZ_FOUR: begin
          idValid <= 1'b1;
          idBytes <= BYTES_FOUR;
        end
        IDSZ_SEVEN: begin
          idValid <= 1'b1;
          idBytes <= BYTES_SEVEN;
        end
        default: begin
          idValid <= 1'b0; // Reserved size
          idBytes <= 3'h0;
        end
      endcase
      // Also steers PM demodulation; host keeps it clear for PM
      phaseShift90 <= auxReg[PHASE_BIT];
      rxCorrelation <= ~auxReg[CORR_BIT];
      rxModeInvalid <= auxReg[CORR_BIT]; // Reserved setting flagged
    end
  end

  // ----------------------------------------------------------------
  // Field-on commands
  // ----------------------------------------------------------------
  // Capture n when a field-on command starts and hold it until done,
  // so a late register write cannot disturb a running command
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fonState <= NPC_FON_IDLE;
      fieldOnBusy <= 1'b0;
      fieldOnN <= 2'h0;
    end else if (ce) begin
      case (fonState)
        NPC_FON_IDLE: begin
          if (fieldOnCmd) begin
            fonState <= NPC_FON_ACTIVE;
            fieldOnBusy <= 1'b1;
            fieldOnN <= auxReg[FON_LSB +: 2];
          end
        end
        NPC_FON_ACTIVE: begin
          if (fieldOnDone) begin
            fonState <= NPC_FON_IDLE;
            fieldOnBusy <= 1'b0;
          end
        end
        default: begin
          fonState <= NPC_FON_IDLE;
          fieldOnBusy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_fdt;
    ce |=> fdtCount == NOMINAL_FDT_FC[FDT_W-1:0] - FDT_W'($past(passiveReg[7:4]));
  endproperty
  a_fdt: assert property (p_fdt) else $error("frame delay not nominal minus trim");

  property p_ap2p;
    ce |=> target.ap2pRecogEn == !$past(passiveReg[3]);
  endproperty
  a_ap2p: assert property (p_ap2p) else $error("peer recognition enable wrong");

  property p_typef;
    ce |=> target.autoTypeFEn != $past(passiveReg[2]);
  endproperty
  a_typef: assert property (p_typef) else $error("type-F answer enable wrong");

  property p_typea;
    ce && passiveReg[0] |=> !target.autoTypeAEn;
  endproperty
  a_typea: assert property (p_typea) else $error("type-A anticollision not off");

  property p_fifo;
    ce |=> target.fifoOnly == ($past(passiveReg[2]) && $past(passiveReg[0]));
  endproperty
  a_fifo: assert property (p_fifo) else $error("automatic answer left on");

  property p_scf;
    ce && streamReg[6:5] == 2'h1 |=> stream.subMode && stream.scDiv == 8'h20;
  endproperty
  a_scf: assert property (p_scf) else $error("subcarrier divider not 32");

  property p_scp;
    ce |=> stream.pulseValid == $past(streamReg[4]);
  endproperty
  a_scp: assert property (p_scp) else $error("pulse code validity wrong");

  property p_stx;
    ce && streamReg[2:0] == 3'h3 |=> stream.txValid && stream.txDiv == 8'h10;
  endproperty
  a_stx: assert property (p_stx) else $error("modulator divider not 16");

  property p_crc;
    ce && auxReg[7] |=> !rxCrcCheck;
  endproperty
  a_crc: assert property (p_crc) else $error("CRC checked while disabled");

  sequence s_reqa;
    ce && (txReqaCmd || txWupaCmd);
  endsequence
  sequence s_noDone;
    (ce && !rxFrameDone && !txReqaCmd && !txWupaCmd) [*2];
  endsequence
  property p_skip;
    s_reqa ##1 s_noDone |-> !rxCrcCheck;
  endproperty
  a_skip: assert property (p_skip) else $error("CRC checked on REQA answer");

  property p_idsz;
    ce && auxReg[5:4] == 2'h1 |=> idValid && idBytes == 3'h7;
  endproperty
  a_idsz: assert property (p_idsz) else $error("identifier size not seven");

  property p_phase;
    ce |=> phaseShift90 == $past(auxReg[3]) && rxCorrelation == !$past(auxReg[2]);
  endproperty
  a_phase: assert property (p_phase) else $error("phase or receiver select wrong");

  sequence s_fonStart;
    ce && fieldOnCmd && fonState == NPC_FON_IDLE;
  endsequence
  property p_fon;
    s_fonStart |=> fieldOnBusy && fieldOnN == $past(auxReg[1:0]);
  endproperty
  a_fon: assert property (p_fon) else $error("field-on n not captured");

  property p_read;
    ce && rdStrobe && addr == 8'h0a |=> rdData == $past(auxReg) && !rdData[6];
  endproperty
  a_read: assert property (p_read) else $error("read-back wrong");

endmodule // npc_config_regs

// ---- rtl/npc_pkg.sv ----
// Purpose: Shared constants and carrier types for the protocol configuration bank
// Assumes: 8-bit register port, one clock (mclk), carrier fc = 13.56 MHz
// Notes:   Offsets are the printed register addresses, used directly as port addresses
package npc_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PASSIVE = 8'h08; // passive_target_definition
  localparam logic [7:0] ADDR_STREAM = 8'h09;  // stream_mode_definition
  localparam logic [7:0] ADDR_AUX = 8'h0a;     // auxiliary_definition
  localparam logic [7:0] RESET_VAL = 8'h00;    // All three registers reset to zero
  localparam logic [7:0] READ_IDLE = 8'h00;    // Read data outside a read answer

  // Writable bits; unused and reserved bits stay zero
  localparam logic [7:0] MASK_PASSIVE = 8'hfd; // Bit 1 reserved
  localparam logic [7:0] MASK_STREAM = 8'h7f;  // Bit 7 unused
  localparam logic [7:0] MASK_AUX = 8'hbf;     // Bit 6 reserved

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FDEL_LSB = 4;  // Frame delay trim, 4 bits
  localparam int AP2P_BIT = 3;  // active_p2p_recog_off
  localparam int TYPEF_BIT = 2; // auto_type_f_reply_off
  localparam int TYPEA_BIT = 0; // auto_type_a_anticoll_off
  localparam int SCF_LSB = 5;   // Subcarrier frequency, 2 bits
  localparam int SCP_LSB = 3;   // Pulse count, 2 bits
  localparam int STX_LSB = 0;   // Transmit period, 3 bits
  localparam int CRC_BIT = 7;   // Receive without CRC check
  localparam int IDSZ_LSB = 4;  // target_id_size, 2 bits
  localparam int PHASE_BIT = 3; // phase_clock_shift
  localparam int CORR_BIT = 2;  // Receiver operation select
  localparam int FON_LSB = 0;   // Field-on count n, 2 bits

  // ----------------------------------------------------------------
  // Field codes and decoded values
  // ----------------------------------------------------------------
  localparam logic [1:0] SCF_BPSK = 2'h0;   // fc/16 BPSK stream
  localparam logic [1:0] SCF_SUB = 2'h1;    // fc/32 subcarrier stream
  localparam logic [1:0] SCP_FOUR = 2'h2;   // 4 pulses
  localparam logic [1:0] SCP_EIGHT = 2'h3;  // 8 pulses
  localparam logic [1:0] IDSZ_FOUR = 2'h0;  // 4-byte identifier
  localparam logic [1:0] IDSZ_SEVEN = 2'h1; // 7-byte identifier
  localparam logic [7:0] DIV_SUB = 8'h20;   // fc/32
  localparam logic [7:0] DIV_BPSK = 8'h10;  // fc/16
  localparam logic [7:0] DIV_TX_BASE = 8'h80; // fc/128, halved per code step
  localparam logic [3:0] PULSES_FOUR = 4'h4;
  localparam logic [3:0] PULSES_EIGHT = 4'h8;
  localparam logic [2:0] BYTES_FOUR = 3'h4;
  localparam logic [2:0] BYTES_SEVEN = 3'h7;
  localparam logic [3:0] FDEL_ADVISED = 4'h2; // Good trim for typical filters

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ap2pRecogEn;   // Active peer-to-peer frame recognition on
    logic autoTypeFEn;   // Automatic type-F polling answer on
    logic autoTypeAEn;   // Automatic type-A anticollision on
    logic fifoOnly;      // No automatic answers; host drives the FIFO
  } npc_target_t;

  typedef struct packed {
    logic subMode;       // Subcarrier stream frequency selected
    logic bpskMode;      // BPSK stream frequency selected
    logic [7:0] scDiv;   // Carrier divider of the stream frequency
    logic pulseValid;    // Pulse count code is usable
    logic [3:0] pulses;  // Subcarrier pulses per report period
    logic txValid;       // Modulator period code is usable
    logic [7:0] txDiv;   // Carrier divider of the modulator period
  } npc_stream_t;

  typedef enum {NPC_FON_IDLE, NPC_FON_ACTIVE} npc_fon_state_t;

endpackage

// ---- rtl/npc_reg8.sv ----
// Purpose: One 8-bit software register with a mask of writable bits
// Assumes: Same-clock write strobe and data
// Notes:   Masked bits are never stored, so they read as zero
`timescale 1ns/10ps
module npc_reg8 #(
  parameter logic [7:0] WMASK = 8'hff,
  parameter logic [7:0] RESET = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  output logic [7:0] q
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Load the writable bits on a write; hold while ce is low
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= RESET;
    end else if (ce && wrEn) begin
      q <= wrData & WMASK;
    end
  end

endmodule // npc_reg8

// ---- verif/npc_rf_model.sv ----
// Purpose: Behavioural RF framing logic facing the configuration bank
// Assumes: One clock (mclk), asynchronous active-high reset
// Notes:   Bench requests an event by code; pulses follow one edge later
`timescale 1ns/10ps
module npc_rf_model #(
  parameter int DONE_DLY = 20 // Field-on duration in mclk cycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic opGo,
  input wire logic [1:0] op,
  input wire logic antiCollReq,
  output logic txReqaCmd,
  output logic txWupaCmd,
  output logic antiCollFrame,
  output logic rxFrameDone,
  output logic fieldOnCmd,
  output logic fieldOnDone
);
  int cnt; // Cycles left of the running field-on command

  // Event pulses: 0 REQA, 1 WUPA, 2 frame end, 3 field-on start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txReqaCmd <= 1'b0;
      txWupaCmd <= 1'b0;
      rxFrameDone <= 1'b0;
      fieldOnCmd <= 1'b0;
      antiCollFrame <= 1'b0;
    end else begin
      txReqaCmd <= opGo && op == 2'h0;
      txWupaCmd <= opGo && op == 2'h1;
      rxFrameDone <= opGo && op == 2'h2;
      fieldOnCmd <= opGo && op == 2'h3;
      antiCollFrame <= antiCollReq; // Only while reader anticollision runs
    end
  end

  // Field-on timing; a second start while running keeps the first deadline
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      fieldOnDone <= 1'b0;
    end else begin
      fieldOnDone <= cnt == 1;
      if (opGo && op == 2'h3 && cnt == 0) begin
        cnt <= DONE_DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // npc_rf_model

// ---- verif/npc_config_regs_tb.sv ----
// Purpose: Self-checking bench of the protocol configuration bank
// Assumes: 50 MHz mclk, register port answers reads one cycle later
// Notes:   Each scenario task drives the bank and judges the result
`timescale 1ns/10ps
module npc_config_regs_tb;
  import npc_pkg::*;
  localparam logic [15:0] NOM = 16'h0400; // Nominal frame delay given to the bank
  localparam int LIMIT = 20000;           // Cycle ceiling of the whole run
  logic mclk, rst, ce, wrStrobe, rdStrobe, opGo, antiCollReq;
  logic [7:0] addr, wrData, rdData;
  logic [1:0] op, fieldOnN;
  logic txReqaCmd, txWupaCmd, antiCollFrame, rxFrameDone, fieldOnCmd, fieldOnDone;
  logic [15:0] fdtCount;
  npc_target_t target;
  npc_stream_t stream;
  logic rxCrcCheck, idValid, phaseShift90, rxCorrelation, rxModeInvalid, fieldOnBusy;
  logic [2:0] idBytes;
  int error_cnt, checks_done, cyc;

  // ------------------------------------------------------------
  // Instances and clock
  // ------------------------------------------------------------
  npc_config_regs #(.FDT_W(16), .NOMINAL_FDT_FC(NOM)) u_dut (.mclk(mclk), .rst(rst),
    .ce(ce), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .txReqaCmd(txReqaCmd), .txWupaCmd(txWupaCmd),
    .antiCollFrame(antiCollFrame), .rxFrameDone(rxFrameDone), .fieldOnCmd(fieldOnCmd),
    .fieldOnDone(fieldOnDone), .fdtCount(fdtCount), .target(target), .stream(stream),
    .rxCrcCheck(rxCrcCheck), .idValid(idValid), .idBytes(idBytes),
    .phaseShift90(phaseShift90), .rxCorrelation(rxCorrelation),
    .rxModeInvalid(rxModeInvalid), .fieldOnBusy(fieldOnBusy), .fieldOnN(fieldOnN));

  npc_rf_model #(.DONE_DLY(20)) u_rf (.mclk(mclk), .rst(rst), .opGo(opGo), .op(op),
    .antiCollReq(antiCollReq), .txReqaCmd(txReqaCmd), .txWupaCmd(txWupaCmd),
    .antiCollFrame(antiCollFrame), .rxFrameDone(rxFrameDone), .fieldOnCmd(fieldOnCmd),
    .fieldOnDone(fieldOnDone));

  // Clock at 20 ns period
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compare one value, zero-extended
  task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
  endtask

  // Read, check the answer cycle and the idle cycle after it
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    @(negedge mclk);
    chk("rdData", exp, rdData);
    @(negedge mclk);
    chk("rdIdle", 8'h00, rdData);
  endtask

  // Let decoded outputs follow the registers
  task automatic settle();
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Ask the framing model for one event, then let it propagate
  task automatic rf(input logic [1:0] o);
    @(posedge mclk);
    op <= o;
    opGo <= 1'b1;
    @(posedge mclk);
    opGo <= 1'b0;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Expected stream decode from the raw register
  function automatic npc_stream_t exp_stream(input logic [7:0] v);
    npc_stream_t s;
    s = '0;
    s.subMode = v[6:5] == 2'h1;
    s.bpskMode = v[6:5] == 2'h0;
    s.scDiv = s.subMode ? 8'h20 : (s.bpskMode ? 8'h10 : 8'h00);
    s.pulseValid = v[4];
    s.pulses = !v[4] ? 4'h0 : (v[3] ? 4'h8 : 4'h4);
    s.txValid = !v[2];
    s.txDiv = v[2] ? 8'h00 : 8'h80 >> v[1:0];
    return s;
  endfunction

  // Auxiliary decode against a raw value, framing idle
  task automatic chk_aux(input logic [7:0] v);
    chk("rxCrcCheck", !v[7], rxCrcCheck);
    chk("idValid", !v[5], idValid);
    chk("idBytes", v[5] ? 3'h0 : (v[4] ? 3'h7 : 3'h4), idBytes);
    chk("phaseShift90", v[3], phaseShift90);
    chk("rxCorrelation", !v[2], rxCorrelation);
    chk("rxModeInvalid", v[2], rxModeInvalid);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset values of registers and decoded controls
  task automatic t_reset();
    settle();
    rd(ADDR_PASSIVE, 8'h00);
    rd(ADDR_STREAM, 8'h00);
    rd(ADDR_AUX, 8'h00);
    chk("fdtCount", NOM, fdtCount);
    chk("target", 4'he, target);
    chk("stream", exp_stream(8'h00), stream);
    chk_aux(8'h00);
  endtask

  // Every trim value, with the answer-control bits varied
  task automatic t_passive();
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], i[3:0]};
      wr(ADDR_PASSIVE, v);
      settle();
      chk("fdtCount", NOM - v[7:4], fdtCount);
      chk("target", {~v[3], ~v[2], ~v[0], v[2] & v[0]}, target);
      rd(ADDR_PASSIVE, v & 8'hfd);
    end
    wr(ADDR_PASSIVE, 8'h20); // Advised trim of two
    settle();
    chk("fdtCount", NOM - 16'h2, fdtCount);
  endtask

  // All frequency, pulse and period codes, unused bit 7 set
  task automatic t_stream();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {1'b1, i[1:0], i[1:0], i[2:0]};
      wr(ADDR_STREAM, v);
      settle();
      chk("stream", exp_stream(v), stream);
      rd(ADDR_STREAM, v & 8'h7f);
    end
  endtask

  // Auxiliary codes including reserved ones
  task automatic t_aux();
    logic [7:0] tbl [5];
    tbl = '{8'h00, 8'hc9, 8'h1c, 8'h26, 8'hb3};
    foreach (tbl[i]) begin
      wr(ADDR_AUX, tbl[i]);
      settle();
      chk_aux(tbl[i]);
      rd(ADDR_AUX, tbl[i] & 8'hbf);
    end
  endtask

  // Automatic CRC skip for REQA, WUPA and anticollision framing
  task automatic t_crc();
    wr(ADDR_AUX, 8'h00); // Phase shift kept clear
    rf(2'h0);
    chk("rxCrcCheck", 1'b0, rxCrcCheck);
    rf(2'h2);
    chk("rxCrcCheck", 1'b1, rxCrcCheck);
    rf(2'h1);
    chk("rxCrcCheck", 1'b0, rxCrcCheck);
    rf(2'h2);
    chk("rxCrcCheck", 1'b1, rxCrcCheck);
    @(posedge mclk);
    antiCollReq <= 1'b1;
    settle();
    chk("rxCrcCheck", 1'b0, rxCrcCheck);
    @(posedge mclk);
    antiCollReq <= 1'b0;
    settle();
    chk("rxCrcCheck", 1'b1, rxCrcCheck);
    wr(ADDR_AUX, 8'h80);
    rf(2'h0);
    rf(2'h2);
    chk("rxCrcCheck", 1'b0, rxCrcCheck);
  endtask

  // Field-on count captured at start, repeat start while busy ignored
  task automatic t_field_on();
    for (int n = 0; n < 4; n++) begin
      wr(ADDR_AUX, {6'h00, n[1:0]}); // Count written before the command
      rf(2'h3);
      chk("fieldOnBusy", 1'b1, fieldOnBusy);
      chk("fieldOnN", n[1:0], fieldOnN);
      wr(ADDR_AUX, {6'h00, ~n[1:0]});
      rf(2'h3);
      chk("fieldOnN", n[1:0], fieldOnN);
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      chk("fieldOnBusy", 1'b0, fieldOnBusy);
    end
  endtask

  // Writes with clock enable low and to an unmapped address are lost
  task automatic t_ignored();
    wr(8'h0b, 8'hff);
    @(posedge mclk);
    ce <= 1'b0;
    wr(ADDR_STREAM, 8'h55);
    @(posedge mclk);
    ce <= 1'b1;
    rd(ADDR_STREAM, 8'h7f);
    rd(8'h0b, 8'h00);
  endtask

  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    opGo = 1'b0;
    antiCollReq = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
    op = 2'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_passive();
    t_stream();
    t_aux();
    t_crc();
    t_field_on();
    t_ignored();
    report_and_stop();
  end

  // Cycle ceiling against a hang
  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      report_and_stop();
    end
  end
endmodule // npc_config_regs_tb
